// *** nvmpc_consts.svh ***
// nvmpc_consts.svh: offsets, field positions, reset values and sizes of the nvm
// programming controller. assumes inclusion by its bare name.
`ifndef NVMPC_CONSTS_SVH
`define NVMPC_CONSTS_SVH

// register indices (printed offsets) and ahb byte addresses
`define NVMPC_IDX_EE_CTRL 8'h1C
`define NVMPC_IDX_OTP_CTRL 8'h1D
`define NVMPC_ADDR_EE_CTRL 12'h070
`define NVMPC_ADDR_OTP_CTRL 12'h074
// status register of the block's own state
`define NVMPC_ADDR_STATUS 12'h078
// array windows on the ahb bus: one byte per word
`define NVMPC_ADDR_EE_BASE 12'h400
`define NVMPC_ADDR_OTP_BASE 12'h800
`define NVMPC_EE_CPU_BASE 16'h0100
// field positions of the erasable-array control register
`define NVMPC_EE_PUMP_BIT 6
`define NVMPC_EE_ERHI_BIT 4
`define NVMPC_EE_ERLO_BIT 3
`define NVMPC_EE_LATCH_BIT 2
`define NVMPC_EE_RC_BIT 1
`define NVMPC_EE_PWR_BIT 0
`define NVMPC_EE_WMASK 8'h5F
// field positions of the one-time array control register
`define NVMPC_OTP_LATCH_BIT 2
`define NVMPC_OTP_PWR_BIT 0
`define NVMPC_OTP_WMASK 8'h05
// reset values
`define NVMPC_CTRL_RESET 8'h00
`define NVMPC_EE_ERASED 8'hFF
`define NVMPC_OTP_ERASED 8'h00
// array sizes
`define NVMPC_EE_BYTES 128
`define NVMPC_EE_BLOCK_BYTES 32
`define NVMPC_OTP_BYTES 16
`define NVMPC_OTP_GROUP 4

`endif

// *** nvmpc_pkg.sv ***
// nvmpc_pkg.sv: types shared by the nvm programming controller.
// assumes nvmpc_consts.svh alongside.
package nvmpc_pkg;

	// erase-select codes
	typedef enum logic [1:0] {
		NVMPC_OP_PROGRAM = 2'h0,
		NVMPC_OP_BYTE_ERASE = 2'h1,
		NVMPC_OP_BLOCK_ERASE = 2'h2,
		NVMPC_OP_BULK_ERASE = 2'h3
	} nvmpc_op_e;

	// ahb-lite request from the master
	typedef struct packed {
		logic hsel;
		logic [11:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} nvmpc_ahb_req_s;

	// ahb-lite answer of the slave
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} nvmpc_ahb_rsp_s;

	// analog and routing controls
	typedef struct packed {
		logic otp_power_on;
		logic pump_on;
		logic ee_power_on;
		logic nvm_rc_clock_sel;
		logic boot_rom_block;
		logic otp_reads_blocked;
		logic ee_reads_blocked;
	} nvmpc_ctl_s;

endpackage

// *** nvmpc_top.sv ***
// nvmpc_top.sv: nvm programming controller with ahb-lite register and array windows.
// assumes one clock, a single ahb-lite master, and analog parts driven from ctl.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "nvmpc_consts.svh"

module nvmpc_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire nvmpc_pkg::nvmpc_ahb_req_s ahb_req,
	output nvmpc_pkg::nvmpc_ahb_rsp_s ahb_rsp,
	// controls to the analog and rom parts
	output nvmpc_pkg::nvmpc_ctl_s ctl
);
	import nvmpc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers and storage
	logic [7:0] ee_ctrl;
	logic [7:0] otp_ctrl;
	logic [7:0] ee_mem [`NVMPC_EE_BYTES];
	logic [7:0] otp_mem [`NVMPC_OTP_BYTES];
	// captured erasable write
	logic [6:0] ee_lat_addr;
	logic [7:0] ee_lat_data;
	logic ee_lat_valid;
	// captured one-time group write
	logic [1:0] otp_lat_group;
	logic [7:0] otp_lat_data [`NVMPC_OTP_GROUP];
	logic [3:0] otp_lat_valid;
	// ahb data phase
	logic dp_write;
	logic [11:0] dp_addr;
	logic [31:0] rdata;

	////////////////////////////////////////////////////////////////////////////
	// address phase acceptance, decode of the captured address, and the erase-select code
	logic addr_take;
	logic in_ee;
	logic in_otp;
	logic [6:0] ee_idx;
	logic [3:0] otp_idx;
	nvmpc_op_e ee_op;
	// window bases, so that the decode can take their upper bits by part-select
	localparam logic [11:0] ee_window = `NVMPC_ADDR_EE_BASE;
	localparam logic [11:0] otp_window = `NVMPC_ADDR_OTP_BASE;

	assign addr_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
	assign in_ee = (dp_addr[11:9] == ee_window[11:9]);
	assign in_otp = (dp_addr[11:6] == otp_window[11:6]);
	assign ee_idx = dp_addr[8:2];
	assign otp_idx = dp_addr[5:2];
	assign ee_op = nvmpc_op_e'(ee_ctrl[`NVMPC_EE_ERHI_BIT -: 2]);

	// capture the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write <= 1'b0;
			dp_addr <= 12'h000;
		end
		else
		begin
			dp_write <= addr_take && ahb_req.hwrite;
			dp_addr <= addr_take ? ahb_req.haddr : dp_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// erasable-array control register
	logic ee_ctrl_wr;
	logic [7:0] ee_wval;
	assign ee_ctrl_wr = dp_write && (dp_addr == `NVMPC_ADDR_EE_CTRL);

	always_comb
	begin
		ee_wval = ahb_req.hwdata[7:0] & `NVMPC_EE_WMASK;
		// power bit keeps its value unless the latch is already set
		if (!ee_ctrl[`NVMPC_EE_LATCH_BIT])
			ee_wval[`NVMPC_EE_PWR_BIT] = ee_ctrl[`NVMPC_EE_PWR_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ee_ctrl <= `NVMPC_CTRL_RESET;
		else if (ee_ctrl_wr)
			ee_ctrl <= ee_wval;
	end

	////////////////////////////////////////////////////////////////////////////
	// one-time array control register
	logic otp_ctrl_wr;
	logic [7:0] otp_wval;
	assign otp_ctrl_wr = dp_write && (dp_addr == `NVMPC_ADDR_OTP_CTRL);

	always_comb
	begin
		otp_wval = ahb_req.hwdata[7:0] & `NVMPC_OTP_WMASK;
		// power may only rise when latch was already set
		if (!otp_ctrl[`NVMPC_OTP_LATCH_BIT])
			otp_wval[`NVMPC_OTP_PWR_BIT] = 1'b0;
		// dropping the latch drops power too
		if (!otp_wval[`NVMPC_OTP_LATCH_BIT])
			otp_wval[`NVMPC_OTP_PWR_BIT] = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			otp_ctrl <= `NVMPC_CTRL_RESET;
		else if (otp_ctrl_wr)
			otp_ctrl <= otp_wval;
	end

	////////////////////////////////////////////////////////////////////////////
	// erasable-array write capture
	logic ee_arr_wr;
	logic ee_pulse_start;
	// the window holds exactly the array's bytes, so every index in it is valid
	assign ee_arr_wr = dp_write && in_ee;
	// power rising edge commits the captured operation
	assign ee_pulse_start = ee_ctrl_wr && ee_wval[`NVMPC_EE_PWR_BIT]
		&& !ee_ctrl[`NVMPC_EE_PWR_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ee_lat_addr <= 7'h00;
			ee_lat_data <= 8'hFF;
			ee_lat_valid <= 1'b0;
		end
		else if (!ee_ctrl[`NVMPC_EE_LATCH_BIT])
			ee_lat_valid <= 1'b0;
		else if (ee_arr_wr)
		begin
			ee_lat_addr <= ee_idx;
			ee_lat_data <= ahb_req.hwdata[7:0];
			ee_lat_valid <= 1'b1;
		end
	end

	// erasable array cells, starting erased; power needs pump too
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < `NVMPC_EE_BYTES; i++)
				ee_mem[i] <= `NVMPC_EE_ERASED;
		end
		else if (ee_pulse_start && ee_lat_valid && ee_ctrl[`NVMPC_EE_PUMP_BIT])
		begin
			for (int i = 0; i < `NVMPC_EE_BYTES; i++)
			begin
				case (ee_op)
					NVMPC_OP_PROGRAM:
						if (7'(i) == ee_lat_addr)
							ee_mem[i] <= ee_mem[i] & ee_lat_data;
					NVMPC_OP_BYTE_ERASE:
						if (7'(i) == ee_lat_addr)
							ee_mem[i] <= `NVMPC_EE_ERASED;
					NVMPC_OP_BLOCK_ERASE:
						if (7'(i) >> 5 == ee_lat_addr >> 5)
							ee_mem[i] <= `NVMPC_EE_ERASED;
					NVMPC_OP_BULK_ERASE:
						ee_mem[i] <= `NVMPC_EE_ERASED;
					default:
						ee_mem[i] <= ee_mem[i];
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// one-time array write capture, one four-byte group
	logic otp_arr_wr;
	logic otp_pulse_start;
	assign otp_arr_wr = dp_write && in_otp;
	assign otp_pulse_start = otp_ctrl_wr && otp_wval[`NVMPC_OTP_PWR_BIT]
		&& !otp_ctrl[`NVMPC_OTP_PWR_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			otp_lat_group <= 2'h0;
			otp_lat_valid <= 4'h0;
			for (int i = 0; i < `NVMPC_OTP_GROUP; i++)
				otp_lat_data[i] <= 8'h00;
		end
		else if (!otp_ctrl[`NVMPC_OTP_LATCH_BIT])
			otp_lat_valid <= 4'h0;
		else if (otp_arr_wr && (otp_lat_valid == 4'h0 || otp_idx[3:2] == otp_lat_group))
		begin
			otp_lat_group <= otp_idx[3:2];
			otp_lat_valid[otp_idx[1:0]] <= 1'b1;
			otp_lat_data[otp_idx[1:0]] <= ahb_req.hwdata[7:0];
		end
	end

	// one-time cells start unprogrammed; programming only sets bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < `NVMPC_OTP_BYTES; i++)
				otp_mem[i] <= `NVMPC_OTP_ERASED;
		end
		else if (otp_pulse_start)
		begin
			for (int i = 0; i < `NVMPC_OTP_GROUP; i++)
				if (otp_lat_valid[i])
					otp_mem[{otp_lat_group, 2'(i)}] <= otp_mem[{otp_lat_group, 2'(i)}]
						| otp_lat_data[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register values at the coming edge: a read whose address phase meets the
	// data phase of a write already sees that write in the control registers, the read blocks and status bits 2:0, since the read data
	// are registered at the address edge to keep zero wait states
	logic [7:0] next_ee_ctrl;
	logic [7:0] next_otp_ctrl;
	logic next_ee_lat_valid;
	logic next_ee_blocked;
	logic next_otp_blocked;

	always_comb
	begin
		next_ee_ctrl = ee_ctrl_wr ? ee_wval : ee_ctrl;
		next_otp_ctrl = otp_ctrl_wr ? otp_wval : otp_ctrl;
		next_ee_lat_valid = ee_lat_valid;
		if (!ee_ctrl[`NVMPC_EE_LATCH_BIT])
			next_ee_lat_valid = 1'b0;
		else if (ee_arr_wr)
			next_ee_lat_valid = 1'b1;
		next_ee_blocked = next_ee_ctrl[`NVMPC_EE_LATCH_BIT] && next_ee_lat_valid;
		next_otp_blocked = next_otp_ctrl[`NVMPC_OTP_LATCH_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// read decode straight from the address phase
	logic [11:0] rd_addr;
	logic rd_in_ee;
	logic rd_in_otp;
	assign rd_addr = ahb_req.haddr;
	assign rd_in_ee = (rd_addr[11:9] == ee_window[11:9]);
	assign rd_in_otp = (rd_addr[11:6] == otp_window[11:6]);

	// read mux; blocked array reads and unmapped words give zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		if (rd_addr == `NVMPC_ADDR_EE_CTRL)
			rdata[7:0] = next_ee_ctrl;
		else if (rd_addr == `NVMPC_ADDR_OTP_CTRL)
			rdata[7:0] = next_otp_ctrl;
		else if (rd_addr == `NVMPC_ADDR_STATUS)
			rdata[7:0] = {4'h0, otp_lat_valid != 4'h0, next_ee_lat_valid,
				next_otp_blocked, next_ee_blocked};
		else if (rd_in_ee && !next_ee_blocked)
			rdata[7:0] = ee_mem[rd_addr[8:2]];
		else if (rd_in_otp && !next_otp_blocked)
			rdata[7:0] = otp_mem[rd_addr[5:2]];
	end

	// answer register: zero wait states, read data stand for the data phase only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ahb_rsp <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
		else
		begin
			ahb_rsp.hreadyout <= 1'b1;
			ahb_rsp.hresp <= 1'b0;
			ahb_rsp.hrdata <= (addr_take && !ahb_req.hwrite) ? rdata : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// analog controls from register state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctl <= '0;
		else
		begin
			ctl.otp_power_on <= otp_ctrl[`NVMPC_OTP_PWR_BIT];
			ctl.pump_on <= ee_ctrl[`NVMPC_EE_PUMP_BIT] || ee_ctrl[`NVMPC_EE_PWR_BIT];
			ctl.ee_power_on <= ee_ctrl[`NVMPC_EE_PWR_BIT];
			ctl.nvm_rc_clock_sel <= ee_ctrl[`NVMPC_EE_RC_BIT];
			ctl.boot_rom_block <= otp_ctrl[`NVMPC_OTP_LATCH_BIT];
			ctl.otp_reads_blocked <= otp_ctrl[`NVMPC_OTP_LATCH_BIT];
			ctl.ee_reads_blocked <= ee_ctrl[`NVMPC_EE_LATCH_BIT] && ee_lat_valid;
		end
	end

endmodule // nvmpc_top

// *** nvmpc_monitor.sv ***
// nvmpc_monitor.sv: port assertions of the nvm programming controller.
// assumes a bind onto nvmpc_top and nvmpc_consts.svh alongside.
`timescale 1ns/100ps
`include "nvmpc_consts.svh"
module nvmpc_monitor (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// watched ports
	input wire nvmpc_pkg::nvmpc_ahb_req_s ahb_req,
	input wire nvmpc_pkg::nvmpc_ahb_rsp_s ahb_rsp,
	input wire nvmpc_pkg::nvmpc_ctl_s ctl
);
	import nvmpc_pkg::*;
	logic take;
	logic rd_take;
	logic ee_wr;
	logic otp_wr;
	logic ee_rd;
	logic otp_rd;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////
	// accepted write and read address phases
	assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && ahb_req.hwrite;
	assign rd_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite;
	// data phase of a control register access
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ee_wr <= 1'b0;
			otp_wr <= 1'b0;
			ee_rd <= 1'b0;
			otp_rd <= 1'b0;
		end
		else
		begin
			ee_wr <= take && ahb_req.haddr == `NVMPC_ADDR_EE_CTRL;
			otp_wr <= take && ahb_req.haddr == `NVMPC_ADDR_OTP_CTRL;
			ee_rd <= rd_take && ahb_req.haddr == `NVMPC_ADDR_EE_CTRL;
			otp_rd <= rd_take && ahb_req.haddr == `NVMPC_ADDR_OTP_CTRL;
		end
	end
	a_reset_clear: assert property ($rose(hresetn) |-> ctl == '0)
		else $error("controls not clear after reset");
	a_otp_refuse: assert property (otp_wr && ahb_req.hwdata[2] && ahb_req.hwdata[0]
		&& !ctl.boot_rom_block |-> ##2 !ctl.otp_power_on)
		else $error("one-time power set with latch");
	a_otp_power: assert property (otp_wr && ahb_req.hwdata[0] && ctl.boot_rom_block
		&& ahb_req.hwdata[2] |-> ##2 ctl.otp_power_on)
		else $error("one-time power not applied");
	a_otp_unlatch: assert property (otp_wr && !ahb_req.hwdata[2]
		|-> ##2 !ctl.otp_power_on && !ctl.boot_rom_block)
		else $error("one-time power kept after unlatch");
	a_boot_tracks: assert property (ctl.boot_rom_block == ctl.otp_reads_blocked)
		else $error("boot block and read block differ");
	a_rc_select: assert property (ee_wr |-> ##2
		ctl.nvm_rc_clock_sel == $past(ahb_req.hwdata[1], 2))
		else $error("clock select wrong");
	a_pump_bit: assert property (ee_wr && ahb_req.hwdata[6] |-> ##2 ctl.pump_on)
		else $error("pump not on");
	a_power_pump: assert property (ctl.ee_power_on |-> ctl.pump_on)
		else $error("power without pump");
	a_ee_fixed_zero: assert property (ee_rd |-> ahb_rsp.hrdata[7] == 1'b0
		&& ahb_rsp.hrdata[5] == 1'b0 && ahb_rsp.hrdata[31:8] == 24'h000000)
		else $error("erasable control fixed bits not zero");
	a_otp_fixed_zero: assert property (otp_rd |-> ahb_rsp.hrdata[31:3] == 29'h0
		&& ahb_rsp.hrdata[1] == 1'b0)
		else $error("one-time control fixed bits not zero");
	a_otp_power_latch: assert property (otp_rd && ahb_rsp.hrdata[0]
		|-> ahb_rsp.hrdata[2])
		else $error("one-time power read without latch");
endmodule // nvmpc_monitor

// *** tb_nvm_program_control.sv ***
// tb_nvm_program_control.sv: self-checking bench of the nvm programming controller.
// assumes nvmpc_pkg, nvmpc_top and nvmpc_monitor compiled first.
`timescale 1ns/100ps
`include "nvmpc_consts.svh"
module tb_nvm_program_control;
	import nvmpc_pkg::*;
	logic hclk;
	logic hresetn;
	nvmpc_ahb_req_s req;
	nvmpc_ahb_rsp_s rsp;
	nvmpc_ctl_s ctl;
	int n_mismatch;
	int cmp_count;
	logic [31:0] seed;
	logic [31:0] rd;
	logic [31:0] r;
	logic [6:0] i;
	logic [7:0] v;
	logic [7:0] ee_exp [128];
	logic [7:0] otp_exp [16];
	nvmpc_op_e ops [8] = '{NVMPC_OP_PROGRAM, NVMPC_OP_PROGRAM, NVMPC_OP_BLOCK_ERASE,
		NVMPC_OP_PROGRAM, NVMPC_OP_PROGRAM, NVMPC_OP_BYTE_ERASE, NVMPC_OP_PROGRAM,
		NVMPC_OP_BULK_ERASE};
	////////////////////////////////////////////////////////////
	// device under test
	nvmpc_top dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp), .ctl(ctl));
	// 40 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// single slave: its ready is the bus ready
	always @(*) req.hready = rsp.hreadyout;
	// xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// programming only clears bits written zero
	function automatic logic [7:0] ee_eprom_program_control(input logic [7:0] old, input logic [7:0] d);
		return old & d;
	endfunction
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// counts and verdict
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait for ready at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (rsp.hreadyout !== 1'b1 && n < 50);
		if (rsp.hreadyout !== 1'b1)
		begin
			n_mismatch++;
			print_verdict();
		end
	endtask
	// single word transfer, one byte in bits 7:0
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		req.hsel <= 1'b1;
		req.htrans <= 2'h2;
		req.haddr <= a;
		req.hwrite <= w;
		wait_rdy();
		req.hsel <= 1'b0;
		req.htrans <= 2'h0;
		req.hwdata <= {24'h000000, d};
		wait_rdy();
		rd = rsp.hrdata;
	endtask
	// read and compare; every answer must be okay
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h000000, e});
		chk({31'h0, rsp.hresp}, 32'h0000_0000);
	endtask
	// controls after their one-clock lag
	task automatic ctlchk(input logic [6:0] e);
		repeat (2) @(posedge hclk);
		chk({25'h0, ctl}, {25'h0, e});
	endtask
	// whole erasable array against the model
	task automatic ee_verify();
		for (int k = 0; k < 128; k++)
			rdchk(`NVMPC_ADDR_EE_BASE + 12'(k * 4), ee_exp[k]);
	endtask
	// one erasable operation: latch, capture, pulse, release
	task automatic ee_op(input nvmpc_op_e op, input logic [6:0] x, input logic [7:0] d);
		logic [7:0] c;
		c = {3'b010, op, 3'b100};
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, c);
		bus(1'b1, `NVMPC_ADDR_EE_BASE + {3'h0, x, 2'h0}, d);
		rdchk(`NVMPC_ADDR_EE_BASE + {3'h0, x, 2'h0}, 8'h00);
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, c | 8'h01);
		ctlchk(7'h31);
		rdchk(`NVMPC_ADDR_EE_CTRL, c | 8'h01);
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, c);
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, 8'h00);
		case (op)
			NVMPC_OP_PROGRAM: ee_exp[x] = ee_eprom_program_control(ee_exp[x], d);
			NVMPC_OP_BYTE_ERASE: ee_exp[x] = 8'hFF;
			NVMPC_OP_BLOCK_ERASE: for (int k = 0; k < 32; k++) ee_exp[{x[6:5], 5'(k)}] = 8'hFF;
			default: foreach (ee_exp[k]) ee_exp[k] = 8'hFF;
		endcase
	endtask
	// main sequence
	initial
	begin
		seed = 32'h00000054;
		n_mismatch = 0;
		cmp_count = 0;
		hresetn = 1'b0;
		req.hsel = 1'b0;
		req.htrans = 2'h0;
		req.haddr = 12'h000;
		req.hwrite = 1'b0;
		req.hsize = 3'h2;
		req.hwdata = 32'h00000000;
		foreach (ee_exp[k]) ee_exp[k] = 8'hFF;
		foreach (otp_exp[k]) otp_exp[k] = 8'h00;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(`NVMPC_ADDR_EE_CTRL, 8'h00);
		rdchk(`NVMPC_ADDR_OTP_CTRL, 8'h00);
		rdchk(12'h0FC, 8'h00);
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, 8'hFF);
		rdchk(`NVMPC_ADDR_EE_CTRL, 8'h5E);
		ctlchk(7'h28);
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, 8'h00);
		ee_verify();
		for (int k = 0; k < 8; k++)
		begin
			r = rnd();
			i = (ops[k] == NVMPC_OP_PROGRAM) ? r[6:0] : i ^ 7'h07;
			ee_op(ops[k], i, r[15:8]);
			ee_verify();
		end
		bus(1'b1, `NVMPC_ADDR_OTP_CTRL, 8'h05);
		rdchk(`NVMPC_ADDR_OTP_CTRL, 8'h04);
		ctlchk(7'h06);
		r = rnd();
		for (int k = 0; k < 4; k++)
		begin
			// never zero, so a leaking read of a programmed byte shows
			v = (r[15:8] + 8'(k)) | 8'h01;
			bus(1'b1, `NVMPC_ADDR_OTP_BASE + {6'h0, r[1:0], 2'(k), 2'h0}, v);
			otp_exp[{r[1:0], 2'(k)}] |= v;
		end
		bus(1'b1, `NVMPC_ADDR_OTP_BASE + {6'h0, r[1:0] + 2'h1, 4'h0}, 8'hFF);
		rdchk(`NVMPC_ADDR_OTP_BASE + {6'h0, r[1:0], 4'h0}, 8'h00);
		bus(1'b1, `NVMPC_ADDR_OTP_CTRL, 8'h05);
		ctlchk(7'h46);
		rdchk(`NVMPC_ADDR_OTP_CTRL, 8'h05);
		bus(1'b1, `NVMPC_ADDR_OTP_CTRL, 8'h00);
		rdchk(`NVMPC_ADDR_OTP_CTRL, 8'h00);
		ctlchk(7'h00);
		for (int k = 0; k < 16; k++)
			rdchk(`NVMPC_ADDR_OTP_BASE + 12'(k * 4), otp_exp[k]);
		// latched again: a programmed byte must not be readable
		bus(1'b1, `NVMPC_ADDR_OTP_CTRL, 8'h04);
		rdchk(`NVMPC_ADDR_OTP_BASE + {6'h0, r[1:0], 4'h0}, 8'h00);
		// reset in mid-run with both registers holding set bits
		bus(1'b1, `NVMPC_ADDR_EE_CTRL, 8'h5E);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ctlchk(7'h00);
		rdchk(`NVMPC_ADDR_EE_CTRL, 8'h00);
		rdchk(`NVMPC_ADDR_OTP_CTRL, 8'h00);
		print_verdict();
	end
endmodule // tb_nvm_program_control

// checker beside the design's ports
bind nvmpc_top nvmpc_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
	.ahb_rsp(ahb_rsp), .ctl(ctl));
